// [include/duart_bus_if.sv]
// pins between the host processor end and the dual-channel port end
// resolves the shared data bus and the interrupt wires from the enables
`timescale 1ns/100ps
`default_nettype none
interface duart_bus_if;
	import duart_port_pkg::*;

	logic       mode_strap;
	logic [2:0] addr;
	logic       read_strobe_n;
	logic       write_strobe_n;
	logic       chan_a_select_n;
	logic       chan_b_select_n;
	logic [7:0] host_data;
	logic       host_data_oe;
	logic [7:0] dev_data;
	logic       dev_data_oe;
	logic       chan_a_interrupt_out;
	logic       chan_a_interrupt_oe;
	logic       chan_b_interrupt_out;
	logic       chan_b_interrupt_oe;
	logic       chan_a_user_output2_n;
	logic       chan_b_user_output2_n;
	logic [7:0] data_bus;
	logic       chan_a_interrupt_wire;
	logic       chan_b_interrupt_wire;

	// bus pulled high when undriven; channel A interrupt is pulled up only as an open drain
	assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : BUS_IDLE_VAL);
	assign chan_a_interrupt_wire = chan_a_interrupt_oe ? chan_a_interrupt_out : (mode_strap == MODE_RW_LINE);
	assign chan_b_interrupt_wire = chan_b_interrupt_oe ? chan_b_interrupt_out : 1'h0;

	modport dev_end
	(
		input  mode_strap, addr, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n, data_bus,
		output dev_data, dev_data_oe, chan_a_interrupt_out, chan_a_interrupt_oe,
		output chan_b_interrupt_out, chan_b_interrupt_oe, chan_a_user_output2_n, chan_b_user_output2_n
	);

	modport host_end
	(
		output mode_strap, addr, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
		output host_data, host_data_oe,
		input  data_bus, chan_a_interrupt_wire, chan_b_interrupt_wire, chan_a_user_output2_n, chan_b_user_output2_n
	);
endinterface
`default_nettype wire

// [include/duart_port_pkg.sv]
// constants shared by both ends of the dual-channel parallel host port
// assumes a single 250 MHz ref_clk on both ends
package duart_port_pkg;

	localparam int        CLK_PERIOD_NS  = 4;
	localparam int        NUM_CHANNELS   = 2;
	localparam int        REGS_PER_CHAN  = 8;
	localparam int        ADDR_W         = 3;
	localparam int        DATA_W         = 8;
	localparam logic      MODE_STROBE    = 1'h1;
	localparam logic      MODE_RW_LINE   = 1'h0;
	localparam logic      RW_DIR_READ    = 1'h1;
	localparam logic      RW_DIR_WRITE   = 1'h0;
	localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
	localparam int        MCR_OUT2_BIT   = 3;
	localparam logic [7:0] REG_RESET_VAL  = 8'h00;
	localparam logic [7:0] BUS_IDLE_VAL   = 8'hFF;

	// host-side pin timing, least times rounded up to whole cycles
	localparam int SETUP_NS       = 8;
	localparam int STROBE_NS      = 40;
	localparam int HOLD_NS        = 16;
	localparam int RECOVER_NS     = 40;
	localparam int SETUP_CYCLES   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYCLES  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYCLES    = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYCLES = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		DEV_IDLE  = 2'h0,
		DEV_READ  = 2'h1,
		DEV_WRITE = 2'h3
	} dev_state_t;

	typedef enum logic [2:0]
	{
		HST_IDLE    = 3'h0,
		HST_SETUP   = 3'h1,
		HST_STROBE  = 3'h3,
		HST_HOLD    = 3'h2,
		HST_RECOVER = 3'h6
	} host_state_t;

endpackage

// [tb/duart_port_props.sv]
// pin-level checks between the host end and the device end of the port
// assumes one ref_clk domain; tb instantiates it beside the interface
`timescale 1ns/100ps
`default_nettype none
module duart_port_props
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic mode_strap,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic chan_a_interrupt_out,
	input wire logic chan_a_interrupt_oe,
	input wire logic chan_b_interrupt_oe,
	input wire logic chan_b_interrupt_wire,
	input wire logic chan_a_user_output2_n,
	input wire logic chan_b_user_output2_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_strobe_steady;
		mode_strap [*6];
	endsequence
	sequence s_rwline_steady;
		!mode_strap [*6];
	endsequence
	sequence s_strobe_read;
		mode_strap && !(chan_a_select_n && chan_b_select_n) && $fell(read_strobe_n);
	endsequence
	sequence s_rwline_read;
		!mode_strap && write_strobe_n && $fell(chan_a_select_n);
	endsequence

	property p_read_drive;
		s_strobe_read |-> ##[3:5] dev_data_oe;
	endproperty
	property p_rw_read_drive;
		s_rwline_read |-> ##[3:5] dev_data_oe;
	endproperty
	property p_read_release;
		mode_strap && $rose(read_strobe_n) |-> ##[1:5] !dev_data_oe;
	endproperty
	property p_no_fight;
		!(dev_data_oe && host_data_oe);
	endproperty
	property p_drive_cause;
		$rose(dev_data_oe) |-> (mode_strap ? !read_strobe_n : write_strobe_n);
	endproperty
	property p_rw_write_quiet;
		!mode_strap && !write_strobe_n && !chan_a_select_n |-> !dev_data_oe;
	endproperty
	property p_gate_a;
		s_strobe_steady |-> chan_a_interrupt_oe == !chan_a_user_output2_n;
	endproperty
	property p_gate_b;
		s_strobe_steady |-> chan_b_interrupt_oe == !chan_b_user_output2_n;
	endproperty
	property p_shared_drain;
		s_rwline_steady |-> chan_a_interrupt_out == 1'h0;
	endproperty
	property p_b_unused;
		s_rwline_steady |-> chan_b_interrupt_oe && chan_b_interrupt_wire == 1'h0;
	endproperty

	a_read_drive: assert property (p_read_drive) else $error("read strobe did not drive data");
	a_rw_read_drive: assert property (p_rw_read_drive) else $error("rw read did not drive data");
	a_read_release: assert property (p_read_release) else $error("data bus not released");
	a_no_fight: assert property (p_no_fight) else $error("both ends drive the data bus");
	a_drive_cause: assert property (p_drive_cause) else $error("data driven outside a read");
	a_rw_write_quiet: assert property (p_rw_write_quiet) else $error("data driven during rw write");
	a_gate_a: assert property (p_gate_a) else $error("channel A gating wrong");
	a_gate_b: assert property (p_gate_b) else $error("channel B gating wrong");
	a_shared_drain: assert property (p_shared_drain) else $error("shared interrupt drove high");
	a_b_unused: assert property (p_b_unused) else $error("channel B interrupt not held low");
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench: host end and device end joined by the pin interface
// assumes stimulus only at the host command port, strap and irq_pending
`timescale 1ns/100ps
`default_nettype none
module tb;
	import duart_port_pkg::*;
	logic       ref_clk;
	logic       rst;
	logic       strap;
	logic       cmd_valid;
	logic       cmd_write;
	logic       cmd_chan;
	logic [2:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       irq_a;
	logic       irq_b;
	logic [1:0] irq_pending;
	logic [7:0] rd_byte;
	logic       wr_pulse;
	logic       wr_chan;
	logic [2:0] wr_addr;
	logic [7:0] wr_data;
	logic       rd_pulse;
	logic       mode_strobe;
	int         wr_seen;
	int         rd_seen;
	int         failures;
	int         tests_run;

	duart_bus_if bus ();
	duart_port_dev duart_port_dev_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus), .irq_pending(irq_pending),
		.wr_pulse(wr_pulse), .wr_chan(wr_chan), .wr_addr(wr_addr), .wr_data(wr_data), .rd_pulse(rd_pulse),
		.mode_strobe(mode_strobe));
	duart_port_host duart_port_host_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus), .mode_strap(strap),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_chan(cmd_chan), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.irq_a(irq_a), .irq_b(irq_b));
	duart_port_props duart_port_props_inst (.ref_clk(ref_clk), .rst(rst), .mode_strap(bus.mode_strap),
		.read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
		.chan_a_select_n(bus.chan_a_select_n), .chan_b_select_n(bus.chan_b_select_n),
		.host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
		.chan_a_interrupt_out(bus.chan_a_interrupt_out), .chan_a_interrupt_oe(bus.chan_a_interrupt_oe),
		.chan_b_interrupt_oe(bus.chan_b_interrupt_oe), .chan_b_interrupt_wire(bus.chan_b_interrupt_wire),
		.chan_a_user_output2_n(bus.chan_a_user_output2_n), .chan_b_user_output2_n(bus.chan_b_user_output2_n));

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// counts device store and read pulses at mid-cycle, where they are settled
	always @(negedge ref_clk)
	begin
		if (wr_pulse === 1'h1)
			wr_seen++;
		if (rd_pulse === 1'h1)
			rd_seen++;
	end

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// waits for the host to go idle, catching any read answer on the way
	task automatic wait_ready;
		int n;
		n = 0;
		while (cmd_ready !== 1'h1 && n < 60)
		begin
			if (rsp_valid === 1'h1)
				rd_byte = rsp_data;
			cycles(1);
			n++;
		end
		check("cmd_ready", 8'h01, {7'h00, cmd_ready});
	endtask

	task automatic do_cmd(input logic wr, input logic ch, input logic [2:0] a, input logic [7:0] d);
		int w0;
		int r0;
		wait_ready();
		w0 = wr_seen;
		r0 = rd_seen;
		rd_byte = 8'hXX;
		cmd_valid = 1'h1;
		cmd_write = wr;
		cmd_chan = ch;
		cmd_addr = a;
		cmd_wdata = d;
		cycles(1);
		cmd_valid = 1'h0;
		wait_ready();
		check("wr_pulse count", {7'h00, wr}, 8'(wr_seen - w0));
		check("rd_pulse count", {7'h00, !wr}, 8'(rd_seen - r0));
		if (wr)
		begin
			check("wr_data", d, wr_data);
			check("wr_addr", {5'h00, a}, {5'h00, wr_addr});
			check("wr_chan", {7'h00, ch}, {7'h00, wr_chan});
		end
	endtask

	function automatic logic [7:0] fill_val(input logic ch, input logic [2:0] i);
		return {(ch ? 4'hA : 4'h5), 1'h0, i};
	endfunction

	task automatic read_all;
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 8; i++)
			begin
				do_cmd(1'h0, c[0], i[2:0], 8'h00);
				check("readback", fill_val(c[0], i[2:0]), rd_byte);
			end
	endtask

	task automatic t_strobe_regs;
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 8; i++)
				do_cmd(1'h1, c[0], i[2:0], fill_val(c[0], i[2:0]));
		read_all();
	endtask

	task automatic t_rw_regs;
		strap = MODE_RW_LINE;
		cycles(10);
		check("mode_strobe", 8'h00, {7'h00, mode_strobe});
		read_all();
		do_cmd(1'h1, 1'h0, 3'h2, 8'h3C);
		do_cmd(1'h1, 1'h1, 3'h2, 8'hC3);
		do_cmd(1'h0, 1'h0, 3'h2, 8'h00);
		check("rw chan A", 8'h3C, rd_byte);
		do_cmd(1'h0, 1'h1, 3'h2, 8'h00);
		check("rw chan B", 8'hC3, rd_byte);
	endtask

	task automatic t_rw_irq;
		logic [1:0] pend [4];
		pend = '{2'h1, 2'h2, 2'h3, 2'h0};
		foreach (pend[k])
		begin
			irq_pending = pend[k];
			cycles(6);
			check("shared irq", {7'h00, |pend[k]}, {7'h00, irq_a});
			check("shared wire", {7'h00, ~|pend[k]}, {7'h00, bus.chan_a_interrupt_wire});
			check("irq b", 8'h00, {7'h00, irq_b});
			check("b pin driven", 8'h01, {7'h00, bus.chan_b_interrupt_oe});
		end
	endtask

	task automatic t_strobe_irq;
		strap = MODE_STROBE;
		cycles(10);
		check("mode_strobe", 8'h01, {7'h00, mode_strobe});
		for (int c = 0; c < 2; c++)
		begin
			do_cmd(1'h1, c[0], OFS_MODEM_CTRL, 8'h08);
			irq_pending = c[0] ? 2'h2 : 2'h1;
			cycles(6);
			check("out2", 8'h00, {7'h00, c[0] ? bus.chan_b_user_output2_n : bus.chan_a_user_output2_n});
			check("irq on", 8'h01, {7'h00, c[0] ? irq_b : irq_a});
			irq_pending = 2'h0;
			cycles(6);
			check("irq off", 8'h00, {7'h00, c[0] ? irq_b : irq_a});
			do_cmd(1'h1, c[0], OFS_MODEM_CTRL, 8'h00);
			irq_pending = 2'h3;
			cycles(6);
			check("out2 off", 8'h01, {7'h00, c[0] ? bus.chan_b_user_output2_n : bus.chan_a_user_output2_n});
			check("irq gated", 8'h00, {7'h00, c[0] ? irq_b : irq_a});
			irq_pending = 2'h0;
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		ref_clk = 1'h0;
		forever #(CLK_PERIOD_NS / 2.0) ref_clk = ~ref_clk;
	end

	initial
	begin
		#(CLK_PERIOD_NS * 10000);
		failures++;
		$display("mismatch watchdog expected done seen hang");
		tally_and_finish();
	end

	initial
	begin
		failures = 0;
		tests_run = 0;
		rst = 1'h1;
		strap = MODE_STROBE;
		cmd_valid = 1'h0;
		cmd_write = 1'h0;
		cmd_chan = 1'h0;
		cmd_addr = 3'h0;
		cmd_wdata = 8'h00;
		irq_pending = 2'h0;
		cycles(4);
		rst = 1'h0;
		t_strobe_regs();
		t_rw_regs();
		t_rw_irq();
		t_strobe_irq();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [verilog/duart_port_dev.sv]
// device end of the dual-channel parallel host port: bus decode, register store, interrupt pins
// assumes host pins arrive asynchronously; irq_pending comes from logic on ref_clk
// Contract
// - strap high strobe style, low read/write line
// - three address bits pick channel register
// - eight-bit data bus driven only on reads
// - read strobe fall starts read, drives data
// - host captures read data at strobe rise
// - write strobe fall starts write cycle
// - write strobe rise stores bus byte
// - read/write-line mode ignores read strobe
// - write strobe is direction: 1 read
// - strobe mode: select A low enables A
// - strobe mode: select B low enables B
// - read/write-line: select A is chip select
// - read/write-line: select B picks channel
// - A modem bit3 set: drive interrupt, output2 low
// - A modem bit3 clear: float interrupt, output2 high
// - read/write-line: A pin shared open-drain interrupt
// - channel B gated like channel A
// - read/write-line: B interrupt held low
`timescale 1ns/100ps
`default_nettype none
module duart_port_dev
	import duart_port_pkg::*;
#(
	parameter int NUM_REGS = NUM_CHANNELS * REGS_PER_CHAN
)
(
	input  wire logic         ref_clk,
	input  wire logic         rst,
	duart_bus_if.dev_end      bus,
	input  wire logic [1:0]   irq_pending,
	output logic              wr_pulse,
	output logic              wr_chan,
	output logic [2:0]        wr_addr,
	output logic [7:0]        wr_data,
	output logic              rd_pulse,
	output logic              mode_strobe
);

	logic [15:0] meta_r;
	logic [15:0] sync_r;

	logic       s_strap;
	logic       s_rd_n;
	logic       s_wr_n;
	logic       s_csa_n;
	logic       s_csb_n;
	logic [2:0] s_addr;
	logic [7:0] s_data;
	dev_state_t state_r;
	dev_state_t state_nxt;
	logic       chan_r;
	logic       chan_nxt;
	logic [2:0] addr_r;
	logic [2:0] addr_nxt;
	logic [7:0] regs_r   [NUM_REGS];
	logic [7:0] regs_nxt [NUM_REGS];
	logic [7:0] dout_r;
	logic [7:0] dout_nxt;
	logic       doe_r;
	logic       doe_nxt;
	logic       ia_out_r;
	logic       ia_out_nxt;
	logic       ia_oe_r;
	logic       ia_oe_nxt;
	logic       ib_out_r;
	logic       ib_out_nxt;
	logic       ib_oe_r;
	logic       ib_oe_nxt;
	logic       chan_a_user_output2_n_n_r;
	logic       chan_a_user_output2_n_n_nxt;
	logic       chan_b_user_output2_n_n_r;
	logic       chan_b_user_output2_n_n_nxt;
	logic       wr_pulse_r;
	logic       wr_pulse_nxt;
	logic       wr_chan_r;
	logic       wr_chan_nxt;
	logic [2:0] wr_addr_r;
	logic [2:0] wr_addr_nxt;
	logic [7:0] wr_data_r;
	logic [7:0] wr_data_nxt;
	logic       rd_pulse_r;
	logic       rd_pulse_nxt;
	logic       mode_r;
	logic       mode_nxt;
	logic       sel_any;
	logic       sel_chan;
	logic       rd_act;
	logic       wr_act;
	logic       mcr_a;
	logic       mcr_b;

	// every host pin passes two flops before use
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= 16'hFFFF;
			sync_r <= 16'hFFFF;
		end
		else
		begin
			meta_r <= {bus.mode_strap, bus.read_strobe_n, bus.write_strobe_n, bus.chan_a_select_n,
				bus.chan_b_select_n, bus.addr, bus.data_bus};
			sync_r <= meta_r;
		end
	end

	assign {s_strap, s_rd_n, s_wr_n, s_csa_n, s_csb_n, s_addr, s_data} = sync_r;
	// access decode for both bus styles
	always_comb
	begin
		if (s_strap == MODE_STROBE)
		begin
			sel_any  = !s_csa_n || !s_csb_n;
			sel_chan = s_csa_n;
			rd_act   = sel_any && !s_rd_n;
			wr_act   = sel_any && !s_wr_n;
		end
		else
		begin
			sel_any  = !s_csa_n;
			sel_chan = s_csb_n;
			rd_act   = sel_any && (s_wr_n == RW_DIR_READ);
			wr_act   = sel_any && (s_wr_n == RW_DIR_WRITE);
		end
	end

	assign mcr_a = regs_r[{1'h0, OFS_MODEM_CTRL}][MCR_OUT2_BIT];
	assign mcr_b = regs_r[{1'h1, OFS_MODEM_CTRL}][MCR_OUT2_BIT];

	always_comb
	begin
		state_nxt    = state_r;
		chan_nxt     = chan_r;
		addr_nxt     = addr_r;
		regs_nxt     = regs_r;
		dout_nxt     = dout_r;
		doe_nxt      = 1'h0;
		wr_pulse_nxt = 1'h0;
		wr_chan_nxt  = wr_chan_r;
		wr_addr_nxt  = wr_addr_r;
		wr_data_nxt  = wr_data_r;
		rd_pulse_nxt = 1'h0;
		mode_nxt     = s_strap;
		case (state_r)
			DEV_IDLE:
			begin
				if (rd_act)
				begin
					state_nxt    = DEV_READ;
					chan_nxt     = sel_chan;
					addr_nxt     = s_addr;
					rd_pulse_nxt = 1'h1;
				end
				else if (wr_act)
				begin
					state_nxt = DEV_WRITE;
					chan_nxt  = sel_chan;
					addr_nxt  = s_addr;
				end
			end
			DEV_READ:
			begin
				if (rd_act)
				begin
					dout_nxt = regs_r[{chan_r, addr_r}];
					doe_nxt  = 1'h1;
				end
				else
					state_nxt = DEV_IDLE;
			end
			DEV_WRITE:
			begin
				if (!wr_act)
				begin
					regs_nxt[{chan_r, addr_r}] = s_data;
					wr_pulse_nxt = 1'h1;
					wr_chan_nxt  = chan_r;
					wr_addr_nxt  = addr_r;
					wr_data_nxt  = s_data;
					state_nxt    = DEV_IDLE;
				end
			end
			default:
				state_nxt = DEV_IDLE;
		endcase
	end

	always_comb
	begin
		chan_a_user_output2_n_n_nxt = !mcr_a;
		chan_b_user_output2_n_n_nxt = !mcr_b;
		if (s_strap == MODE_STROBE)
		begin
			ia_out_nxt = irq_pending[0];
			ia_oe_nxt  = mcr_a;
			ib_out_nxt = irq_pending[1];
			ib_oe_nxt  = mcr_b;
		end
		else
		begin
			ia_out_nxt = 1'h0;
			ia_oe_nxt  = |irq_pending;
			ib_out_nxt = 1'h0;
			ib_oe_nxt  = 1'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r    <= DEV_IDLE;
			chan_r     <= 1'h0;
			addr_r     <= 3'h0;
			regs_r     <= '{default: REG_RESET_VAL};
			dout_r     <= 8'h00;
			doe_r      <= 1'h0;
			ia_out_r   <= 1'h0;
			ia_oe_r    <= 1'h0;
			ib_out_r   <= 1'h0;
			ib_oe_r    <= 1'h0;
			chan_a_user_output2_n_n_r   <= 1'h1;
			chan_b_user_output2_n_n_r   <= 1'h1;
			wr_pulse_r <= 1'h0;
			wr_chan_r  <= 1'h0;
			wr_addr_r  <= 3'h0;
			wr_data_r  <= 8'h00;
			rd_pulse_r <= 1'h0;
			mode_r     <= MODE_STROBE;
		end
		else
		begin
			state_r    <= state_nxt;
			chan_r     <= chan_nxt;
			addr_r     <= addr_nxt;
			regs_r     <= regs_nxt;
			dout_r     <= dout_nxt;
			doe_r      <= doe_nxt;
			ia_out_r   <= ia_out_nxt;
			ia_oe_r    <= ia_oe_nxt;
			ib_out_r   <= ib_out_nxt;
			ib_oe_r    <= ib_oe_nxt;
			chan_a_user_output2_n_n_r   <= chan_a_user_output2_n_n_nxt;
			chan_b_user_output2_n_n_r   <= chan_b_user_output2_n_n_nxt;
			wr_pulse_r <= wr_pulse_nxt;
			wr_chan_r  <= wr_chan_nxt;
			wr_addr_r  <= wr_addr_nxt;
			wr_data_r  <= wr_data_nxt;
			rd_pulse_r <= rd_pulse_nxt;
			mode_r     <= mode_nxt;
		end
	end

	assign bus.dev_data              = dout_r;
	assign bus.dev_data_oe           = doe_r;
	assign bus.chan_a_interrupt_out  = ia_out_r;
	assign bus.chan_a_interrupt_oe   = ia_oe_r;
	assign bus.chan_b_interrupt_out  = ib_out_r;
	assign bus.chan_b_interrupt_oe   = ib_oe_r;
	assign bus.chan_a_user_output2_n = chan_a_user_output2_n_n_r;
	assign bus.chan_b_user_output2_n = chan_b_user_output2_n_n_r;
	assign wr_pulse                  = wr_pulse_r;
	assign wr_chan                   = wr_chan_r;
	assign wr_addr                   = wr_addr_r;
	assign wr_data                   = wr_data_r;
	assign rd_pulse                  = rd_pulse_r;
	assign mode_strobe               = mode_r;

endmodule
`default_nettype wire

// [verilog/duart_port_host.sv]
// host processor end: turns single-word commands into pin cycles of either bus style
// assumes device pins arrive asynchronously and the strap changes only while idle
`timescale 1ns/100ps
`default_nettype none
module duart_port_host
	import duart_port_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	duart_bus_if.host_end   bus,
	input  wire logic       mode_strap,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_write,
	input  wire logic       cmd_chan,
	input  wire logic [2:0] cmd_addr,
	input  wire logic [7:0] cmd_wdata,
	output logic            cmd_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            irq_a,
	output logic            irq_b
);

	logic [9:0] meta_r;
	logic [9:0] sync_r;

	host_state_t state_r;
	host_state_t state_nxt;
	logic [7:0]  cnt_r;
	logic [7:0]  cnt_nxt;
	logic        write_r;
	logic        write_nxt;
	logic        strap_r;
	logic        strap_nxt;
	logic [2:0]  addr_r;
	logic [2:0]  addr_nxt;
	logic        rd_n_r;
	logic        rd_n_nxt;
	logic        wr_n_r;
	logic        wr_n_nxt;
	logic        csa_n_r;
	logic        csa_n_nxt;
	logic        csb_n_r;
	logic        csb_n_nxt;
	logic [7:0]  hdata_r;
	logic [7:0]  hdata_nxt;
	logic        hoe_r;
	logic        hoe_nxt;
	logic        ready_r;
	logic        ready_nxt;
	logic        rsp_valid_r;
	logic        rsp_valid_nxt;
	logic [7:0]  rsp_data_r;
	logic [7:0]  rsp_data_nxt;
	logic        irq_a_r;
	logic        irq_b_r;
	logic        irq_a_nxt;
	logic        irq_b_nxt;
	logic        strobe_mode;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= 10'h000;
			sync_r <= 10'h000;
		end
		else
		begin
			meta_r <= {bus.data_bus, bus.chan_a_interrupt_wire, bus.chan_b_interrupt_wire};
			sync_r <= meta_r;
		end
	end

	assign strobe_mode = (strap_r == MODE_STROBE);

	always_comb
	begin
		state_nxt     = state_r;
		cnt_nxt       = (cnt_r == 8'h00) ? 8'h00 : cnt_r - 8'h01;
		write_nxt     = write_r;
		strap_nxt     = strap_r;
		addr_nxt      = addr_r;
		rd_n_nxt      = rd_n_r;
		wr_n_nxt      = wr_n_r;
		csa_n_nxt     = csa_n_r;
		csb_n_nxt     = csb_n_r;
		hdata_nxt     = hdata_r;
		hoe_nxt       = hoe_r;
		ready_nxt     = ready_r;
		rsp_valid_nxt = 1'h0;
		rsp_data_nxt  = rsp_data_r;
		// shared interrupt is active low in read/write-line mode
		irq_a_nxt     = strobe_mode ? sync_r[1] : !sync_r[1];
		irq_b_nxt     = strobe_mode && sync_r[0];
		case (state_r)
			HST_IDLE:
			begin
				strap_nxt = mode_strap;
				// channel B select must idle high once strobe style is back
				csb_n_nxt = strobe_mode ? 1'h1 : csb_n_r;
				if (cmd_valid && ready_r)
				begin
					state_nxt = HST_SETUP;
					cnt_nxt   = 8'(SETUP_CYCLES - 1);
					ready_nxt = 1'h0;
					write_nxt = cmd_write;
					addr_nxt  = cmd_addr;
					hdata_nxt = cmd_wdata;
					hoe_nxt   = cmd_write;
					if (strap_r == MODE_STROBE)
					begin
						csa_n_nxt = cmd_chan;
						csb_n_nxt = !cmd_chan;
					end
					else
					begin
						csb_n_nxt = cmd_chan;
						wr_n_nxt  = cmd_write ? RW_DIR_WRITE : RW_DIR_READ;
					end
				end
				else
					ready_nxt = 1'h1;
			end
			HST_SETUP:
			begin
				if (cnt_r == 8'h00)
				begin
					state_nxt = HST_STROBE;
					cnt_nxt   = 8'(STROBE_CYCLES - 1);
					if (strobe_mode)
					begin
						rd_n_nxt = write_r;
						wr_n_nxt = !write_r;
					end
					else
					begin
						csa_n_nxt = 1'h0;
					end
				end
			end
			HST_STROBE:
			begin
				if (cnt_r == 8'h00)
				begin
					state_nxt = HST_HOLD;
					cnt_nxt   = 8'(HOLD_CYCLES - 1);
					if (strobe_mode)
					begin
						rd_n_nxt = 1'h1;
						wr_n_nxt = 1'h1;
					end
					else
					begin
						csa_n_nxt = 1'h1;
					end
					if (!write_r)
					begin
						rsp_valid_nxt = 1'h1;
						rsp_data_nxt  = sync_r[9:2];
					end
				end
			end
			HST_HOLD:
			begin
				if (cnt_r == 8'h00)
				begin
					state_nxt = HST_RECOVER;
					cnt_nxt   = 8'(RECOVER_CYCLES - 1);
					csa_n_nxt = 1'h1;
					csb_n_nxt = strobe_mode;
					wr_n_nxt  = 1'h1;
					hoe_nxt   = 1'h0;
				end
			end
			HST_RECOVER:
			begin
				if (cnt_r == 8'h00)
				begin
					state_nxt = HST_IDLE;
					ready_nxt = 1'h1;
				end
			end
			default:
			begin
				state_nxt = HST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r     <= HST_IDLE;
			cnt_r       <= 8'h00;
			write_r     <= 1'h0;
			strap_r     <= MODE_STROBE;
			addr_r      <= 3'h0;
			rd_n_r      <= 1'h1;
			wr_n_r      <= 1'h1;
			csa_n_r     <= 1'h1;
			csb_n_r     <= 1'h1;
			hdata_r     <= 8'h00;
			hoe_r       <= 1'h0;
			ready_r     <= 1'h0;
			rsp_valid_r <= 1'h0;
			rsp_data_r  <= 8'h00;
			irq_a_r     <= 1'h0;
			irq_b_r     <= 1'h0;
		end
		else
		begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			write_r     <= write_nxt;
			strap_r     <= strap_nxt;
			addr_r      <= addr_nxt;
			rd_n_r      <= rd_n_nxt;
			wr_n_r      <= wr_n_nxt;
			csa_n_r     <= csa_n_nxt;
			csb_n_r     <= csb_n_nxt;
			hdata_r     <= hdata_nxt;
			hoe_r       <= hoe_nxt;
			ready_r     <= ready_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r  <= rsp_data_nxt;
			irq_a_r     <= irq_a_nxt;
			irq_b_r     <= irq_b_nxt;
		end
	end

	assign bus.mode_strap      = strap_r;
	assign bus.addr            = addr_r;
	assign bus.read_strobe_n   = rd_n_r;
	assign bus.write_strobe_n  = wr_n_r;
	assign bus.chan_a_select_n = csa_n_r;
	assign bus.chan_b_select_n = csb_n_r;
	assign bus.host_data       = hdata_r;
	assign bus.host_data_oe    = hoe_r;
	assign cmd_ready           = ready_r;
	assign rsp_valid           = rsp_valid_r;
	assign rsp_data            = rsp_data_r;
	assign irq_a               = irq_a_r;
	assign irq_b               = irq_b_r;

endmodule
`default_nettype wire
